// ### hdl/pmc_map.svh
// Register offsets, field positions and reset values of the counter configuration block.
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// ==========================================================================
// Offsets within the monitoring table
`define PMC_ADDR_W 12
`define PMC_FRZ_OFS 12'h020
`define PMC_OVF_OFS 12'h030
`define PMC_CFG_BASE 12'h100
`define PMC_CFG_STRIDE 12'h008

// ==========================================================================
// Fields of counter_event_config
`define PMC_F_EN 0
`define PMC_F_INTR 1
`define PMC_F_FRZ 2
`define PMC_F_CAT_LO 8
`define PMC_F_CAT_HI 11
`define PMC_F_MASK_LO 32
`define PMC_F_MASK_HI 59
`define PMC_MASK_W 28
`define PMC_NUM_CAT 5

// ==========================================================================
// Reset values
`define PMC_CFG_RST 64'h0000_0000_0000_0000
`define PMC_OVF_RST 32'h0000_0000
`define PMC_FRZ_RST 32'h0000_0000

`endif

// ### hdl/pmc_pkg.sv
// Types shared by the counter configuration block.
package pmc_pkg;

    // ======================================================================
    // Event categories selected in counter_event_config.
    typedef enum logic [3:0] {
        PMC_CAT_WORK_QUEUE = 4'h0,
        PMC_CAT_ENGINE = 4'h1,
        PMC_CAT_ADDR_XLATE = 4'h2,
        PMC_CAT_OPERATIONS = 4'h3,
        PMC_CAT_COMPLETIONS = 4'h4
    } pmc_cat_t;

endpackage : pmc_pkg

// ### hdl/pmc_cfg_slot.sv
// One counter's configuration register with its lock and event match.
`timescale 1ns/1ps
`include "pmc_map.svh"

module pmc_cfg_slot
    import pmc_pkg::*;
#(
    parameter logic [`PMC_NUM_CAT*`PMC_MASK_W-1:0] CAT_SUPPORT = {(`PMC_NUM_CAT*`PMC_MASK_W){1'b1}}
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // Register write from the table decoder
    input wire logic i_wr_hit,
    input wire logic [63:0] i_wdata,
    // Category event pulses and freeze state
    input wire logic [`PMC_NUM_CAT*`PMC_MASK_W-1:0] i_cat_events,
    input wire logic i_frozen,
    // Stored configuration and increment pulse
    output logic [63:0] o_cfg,
    output logic o_enable,
    output logic o_intr_sel,
    output logic o_frz_sel,
    output logic o_count_inc
);

    logic en_r;
    logic intr_r;
    logic frz_r;
    logic [3:0] cat_r;
    logic [`PMC_MASK_W-1:0] mask_r;
    logic [`PMC_MASK_W-1:0] supp;
    logic [`PMC_MASK_W-1:0] evts;

    // ======================================================================
    // Register storage
    // Enable is always writable; the other fields only take a write while the
    // counter was disabled before it, so one write can program and enable.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            en_r <= 1'b0;
            intr_r <= 1'b0;
            frz_r <= 1'b0;
            cat_r <= 4'h0;
            mask_r <= {`PMC_MASK_W{1'b0}};
        end else if (i_wr_hit) begin
            en_r <= i_wdata[`PMC_F_EN];
            if (!en_r) begin
                intr_r <= i_wdata[`PMC_F_INTR];
                frz_r <= i_wdata[`PMC_F_FRZ];
                cat_r <= i_wdata[`PMC_F_CAT_HI:`PMC_F_CAT_LO];
                mask_r <= i_wdata[`PMC_F_MASK_HI:`PMC_F_MASK_LO];
            end
        end
    end

    // Reads return stored values even for a discarded write; reserved bits are zero.
    always_comb begin
        o_cfg = `PMC_CFG_RST;
        o_cfg[`PMC_F_EN] = en_r;
        o_cfg[`PMC_F_INTR] = intr_r;
        o_cfg[`PMC_F_FRZ] = frz_r;
        o_cfg[`PMC_F_CAT_HI:`PMC_F_CAT_LO] = cat_r;
        o_cfg[`PMC_F_MASK_HI:`PMC_F_MASK_LO] = mask_r;
    end

    assign o_enable = en_r;
    assign o_intr_sel = intr_r;
    assign o_frz_sel = frz_r;

    // ======================================================================
    // Event match
    // Reserved categories support nothing, so their mask bits are ignored.
    always_comb begin
        supp = {`PMC_MASK_W{1'b0}};
        evts = {`PMC_MASK_W{1'b0}};
        case (cat_r)
            PMC_CAT_WORK_QUEUE, PMC_CAT_ENGINE, PMC_CAT_ADDR_XLATE,
            PMC_CAT_OPERATIONS, PMC_CAT_COMPLETIONS: begin
                supp = CAT_SUPPORT[cat_r*`PMC_MASK_W +: `PMC_MASK_W];
                evts = i_cat_events[cat_r*`PMC_MASK_W +: `PMC_MASK_W];
            end
            default: begin
                supp = {`PMC_MASK_W{1'b0}};
            end
        endcase
    end

    // The increment is a registered pulse; a frozen counter gets none.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_count_inc <= 1'b0;
        end else begin
            o_count_inc <= en_r && !i_frozen && |(mask_r & supp & evts);
        end
    end

endmodule : pmc_cfg_slot

// ### hdl/pmc_config.sv
// Bank of counter configuration registers with overflow flags and freeze control.
`timescale 1ns/1ps
`include "pmc_map.svh"

// Function
// - Every configuration register resets to all zeros, counter disabled.
// - While enabled, all configuration fields except enable ignore writes.
// - Exactly one configuration register per counter, count set by parameter.
// - 64-bit register at table offset 0x100 plus eight times counter index.
// - Bits 59:32 hold the 28-bit event mask.
// - Mask bits unsupported by the selected category are ignored.
// - Bits 11:8 choose category 0..4; values 5..15 reserved.
// - Bit 2 set freezes all enabled counters on overflow; status always recorded.
// - Without freeze support, bit 2 has no effect.
// - Bit 1 set raises a monitoring interrupt on this counter's overflow.
// - Without interrupt support, bit 1 produces no interrupt.
// - Bit 0 is a freely writable enable.
// - Overflow flags hold one bit per counter, set on overflow, write 1 clears.
// - Frozen counters stop counting until unfrozen, then count only if enabled.
module pmc_config
    import pmc_pkg::*;
#(
    parameter int NUM_CNTR = 4,
    parameter logic [`PMC_NUM_CAT*`PMC_MASK_W-1:0] CAT_SUPPORT = {(`PMC_NUM_CAT*`PMC_MASK_W){1'b1}}
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // Memory-mapped register access within the monitoring table
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [`PMC_ADDR_W-1:0] i_reg_addr,
    input wire logic [63:0] i_reg_wdata,
    output logic [63:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // Capability bits of monitor_capability
    input wire logic i_cap_freeze_support,
    input wire logic i_cap_intr_support,
    // Event pulses per category and overflow from the counter data logic
    input wire logic [`PMC_NUM_CAT*`PMC_MASK_W-1:0] i_cat_events,
    input wire logic [NUM_CNTR-1:0] i_cntr_overflow,
    // Counter control
    output logic [NUM_CNTR-1:0] o_count_inc,
    output logic [NUM_CNTR-1:0] o_frozen,
    output logic o_monitor_intr
);

    // Address decode results, shared by the write and read paths.
    logic hit_frz;
    logic hit_ovf;
    logic [NUM_CNTR-1:0] hit_cfg;
    logic [`PMC_ADDR_W-1:0] slot_ofs [NUM_CNTR];
    // Per-slot write strobes and views of the stored configuration.
    logic [NUM_CNTR-1:0] cfg_hit;
    logic [NUM_CNTR-1:0] en;
    logic [NUM_CNTR-1:0] intr_sel;
    logic [NUM_CNTR-1:0] frz_sel;
    logic [63:0] cfg_rd [NUM_CNTR];
    // Status and freeze state.
    logic [NUM_CNTR-1:0] ovf_r;
    logic [NUM_CNTR-1:0] frozen_r;
    logic [NUM_CNTR-1:0] frozen_nxt;
    // Strobes, triggers and read data.
    logic frz_wr;
    logic ovf_wr;
    logic global_freeze;
    logic [NUM_CNTR-1:0] frz_trig;
    logic [NUM_CNTR-1:0] intr_trig;
    logic intr_req;
    logic [63:0] rdata_nxt;

    // ======================================================================
    // Address decode
    // One exact-match decode serves both directions, so a read always returns the
    // register that a write at the same offset would have changed.
    // Writes to unmapped offsets fall through every decode and change nothing.
    always_comb begin
        hit_frz = 1'b0;
        hit_ovf = 1'b0;
        hit_cfg = {NUM_CNTR{1'b0}};
        if (i_reg_addr == `PMC_FRZ_OFS) begin
            hit_frz = 1'b1;
        end else if (i_reg_addr == `PMC_OVF_OFS) begin
            hit_ovf = 1'b1;
        end else begin
            for (int i = 0; i < NUM_CNTR; i++) begin
                if (i_reg_addr == slot_ofs[i]) begin
                    hit_cfg[i] = 1'b1;
                end
            end
        end
    end

    // Without freeze support the freeze register is absent, so its writes are dropped.
    assign frz_wr = i_reg_wr && hit_frz && i_cap_freeze_support;
    assign ovf_wr = i_reg_wr && hit_ovf;

    // ======================================================================
    // Configuration slots, one per counter
    // Each slot keeps its own lock, so one enabled counter never blocks another's setup.
    genvar g;
    generate
        for (g = 0; g < NUM_CNTR; g++) begin : g_slot
            // Slots sit one 64-bit word apart above the configuration base.
            localparam logic [`PMC_ADDR_W-1:0] SLOT_OFS =
                `PMC_CFG_BASE + `PMC_CFG_STRIDE * 12'(g);
            assign slot_ofs[g] = SLOT_OFS;
            assign cfg_hit[g] = i_reg_wr && hit_cfg[g];
            pmc_cfg_slot #(
                .CAT_SUPPORT(CAT_SUPPORT)
            ) u_slot (
                .i_core_clk(i_core_clk),
                .i_resetn(i_resetn),
                .i_wr_hit(cfg_hit[g]),
                .i_wdata(i_reg_wdata),
                .i_cat_events(i_cat_events),
                .i_frozen(frozen_r[g]),
                .o_cfg(cfg_rd[g]),
                .o_enable(en[g]),
                .o_intr_sel(intr_sel[g]),
                .o_frz_sel(frz_sel[g]),
                .o_count_inc(o_count_inc[g])
            );
        end
    endgenerate

    // ======================================================================
    // Overflow flags
    // A new overflow in the cycle of a write-one-to-clear keeps the flag set.
    // Only the low NUM_CNTR bits of a clearing write matter; higher flags do not exist.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            ovf_r <= {NUM_CNTR{1'b0}};
        end else if (ovf_wr) begin
            ovf_r <= (ovf_r & ~i_reg_wdata[NUM_CNTR-1:0]) | i_cntr_overflow;
        end else begin
            ovf_r <= ovf_r | i_cntr_overflow;
        end
    end

    // ======================================================================
    // Freeze state
    // Freeze selects are ignored when freezing is not supported.
    assign frz_trig = i_cntr_overflow & frz_sel;
    assign global_freeze = i_cap_freeze_support && |frz_trig;

    // Disabling clears freeze; an overflow freeze beats a software unfreeze.
    always_comb begin
        frozen_nxt = frozen_r;
        if (frz_wr) begin
            frozen_nxt = i_reg_wdata[NUM_CNTR-1:0];
        end
        if (global_freeze) begin
            frozen_nxt = {NUM_CNTR{1'b1}};
        end
        frozen_nxt = frozen_nxt & en;
    end

    // Freeze state register.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            frozen_r <= {NUM_CNTR{1'b0}};
        end else begin
            frozen_r <= frozen_nxt;
        end
    end

    assign o_frozen = frozen_r;

    // ======================================================================
    // Interrupt request; several counters overflowing together give one pulse,
    // and the overflow flags tell software which of them it was.
    assign intr_trig = i_cntr_overflow & intr_sel;
    assign intr_req = i_cap_intr_support && |intr_trig;

    // Interrupt pulse, one cycle after the overflow.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_monitor_intr <= 1'b0;
        end else begin
            o_monitor_intr <= intr_req;
        end
    end

    // ======================================================================
    // Read path
    // Unmapped offsets read zero; the freeze register reads zero when absent.
    always_comb begin
        rdata_nxt = 64'h0;
        if (hit_frz) begin
            if (i_cap_freeze_support) begin
                rdata_nxt[NUM_CNTR-1:0] = frozen_r;
            end
        end else if (hit_ovf) begin
            rdata_nxt[NUM_CNTR-1:0] = ovf_r;
        end else begin
            for (int i = 0; i < NUM_CNTR; i++) begin
                if (hit_cfg[i]) begin
                    rdata_nxt = cfg_rd[i];
                end
            end
        end
    end

    // The read data register loads only on a read, so it holds between reads.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_reg_rdata <= 64'h0;
        end else if (i_reg_rd) begin
            o_reg_rdata <= rdata_nxt;
        end
    end

    // Every read is answered exactly one cycle after its strobe.
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
        end
    end

endmodule : pmc_config

// ### verif/pmc_config_properties.sv
// Port assertions for the counter configuration bank.
`timescale 1ns/1ps
`include "pmc_map.svh"

module pmc_config_properties #(
    parameter int NUM_CNTR = 4
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // Register access
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [63:0] o_reg_rdata,
    input wire logic o_reg_rvalid,
    // Capabilities, events and counter control
    input wire logic i_cap_freeze_support,
    input wire logic i_cap_intr_support,
    input wire logic [`PMC_NUM_CAT*`PMC_MASK_W-1:0] i_cat_events,
    input wire logic [NUM_CNTR-1:0] i_cntr_overflow,
    input wire logic [NUM_CNTR-1:0] o_count_inc,
    input wire logic [NUM_CNTR-1:0] o_frozen,
    input wire logic o_monitor_intr
);
    // ======================================================================
    // Properties, all in the core clock domain
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);

    a_read_answer: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read strobe not answered");
    a_answer_cause: assert property (o_reg_rvalid |-> $past(i_reg_rd))
        else $error("read answer without strobe");
    a_rdata_holds: assert property (!$past(i_reg_rd) |-> $stable(o_reg_rdata))
        else $error("read data moved without a read");
    a_intr_cause: assert property (o_monitor_intr |->
        $past(i_cap_intr_support) && $past(i_cntr_overflow) != '0)
        else $error("interrupt without supported overflow");
    a_inc_event: assert property (o_count_inc != '0 |-> $past(i_cat_events) != '0)
        else $error("count without any event");
    a_frozen_still: assert property ((o_count_inc & $past(o_frozen)) == '0)
        else $error("frozen counter counted");
    // A counter may only freeze by an overflow or a write, and only with support.
    a_freeze_cause: assert property ((o_frozen & ~$past(o_frozen)) != '0 |->
        $past(i_cap_freeze_support) && ($past(i_cntr_overflow) != '0 || $past(i_reg_wr)))
        else $error("freeze without cause");
    // A disabling write clears the freeze one cycle later than a freeze register write.
    a_thaw_write: assert property (($past(o_frozen) & ~o_frozen) != '0 |->
        $past(i_reg_wr) || $past(i_reg_wr, 2))
        else $error("unfreeze without a write");
endmodule : pmc_config_properties

// Attach the checker to every bank instance.
bind pmc_config pmc_config_properties #(.NUM_CNTR(NUM_CNTR)) i_pmc_config_properties (
    .i_core_clk, .i_resetn, .i_reg_wr, .i_reg_rd, .o_reg_rdata, .o_reg_rvalid,
    .i_cap_freeze_support, .i_cap_intr_support, .i_cat_events, .i_cntr_overflow,
    .o_count_inc, .o_frozen, .o_monitor_intr
);

// ### verif/pmc_config_tb.sv
// Self-checking bench for the counter configuration bank.
`timescale 1ns/1ps
`include "pmc_map.svh"

module pmc_config_tb;
    import pmc_pkg::*;
    localparam int N = 4;
    localparam int EW = `PMC_NUM_CAT*`PMC_MASK_W;
    // Category 1 lacks its top event, so the support filter is exercised.
    localparam logic [EW-1:0] SUP = ~({{(EW-1){1'b0}}, 1'b1} << 55);
    logic i_core_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [`PMC_ADDR_W-1:0] i_reg_addr = '0;
    logic [63:0] i_reg_wdata = '0;
    logic [63:0] o_reg_rdata;
    logic o_reg_rvalid;
    logic i_cap_freeze_support = 1'b1;
    logic i_cap_intr_support = 1'b1;
    logic [EW-1:0] i_cat_events = '0;
    logic [N-1:0] i_cntr_overflow = '0;
    logic [N-1:0] o_count_inc;
    logic [N-1:0] o_frozen;
    logic o_monitor_intr;
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;

    pmc_config #(.NUM_CNTR(N), .CAT_SUPPORT(SUP)) i_pmc_config (
        .i_core_clk, .i_resetn, .i_reg_wr, .i_reg_rd, .i_reg_addr, .i_reg_wdata,
        .o_reg_rdata, .o_reg_rvalid, .i_cap_freeze_support, .i_cap_intr_support,
        .i_cat_events, .i_cntr_overflow, .o_count_inc, .o_frozen, .o_monitor_intr
    );

    // ======================================================================
    // Clock and hang guard
    initial begin
        forever #10 i_core_clk = ~i_core_clk;
    end
    // A hung handshake must not stall the run.
    always @(posedge i_core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            $display("[FAIL] %0t run timed out", $time);
            test_done();
        end
    end

    // ======================================================================
    // Shared tasks
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [11:0] a, input logic [63:0] d);
        @(posedge i_core_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_core_clk);
        i_reg_wr <= 1'b0;
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [63:0] exp);
        @(posedge i_core_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_core_clk);
        i_reg_rd <= 1'b0;
        #1;
        chk({63'h0, o_reg_rvalid}, 64'h1);
        chk(o_reg_rdata, exp);
    endtask : rdc
    task automatic ev(input int b, input logic [N-1:0] exp);
        logic [EW-1:0] e;
        e = '0;
        e[b] = 1'b1;
        @(posedge i_core_clk);
        i_cat_events <= e;
        @(posedge i_core_clk);
        i_cat_events <= '0;
        #1;
        chk(64'(o_count_inc), 64'(exp));
    endtask : ev
    task automatic ovf(input logic [N-1:0] o, input logic irq, input logic [N-1:0] frz);
        @(posedge i_core_clk);
        i_cntr_overflow <= o;
        @(posedge i_core_clk);
        i_cntr_overflow <= '0;
        #1;
        chk({63'h0, o_monitor_intr}, {63'h0, irq});
        chk(64'(o_frozen), 64'(frz));
    endtask : ovf

    // ======================================================================
    // Scenarios
    task automatic t_reset;
        for (int n = 0; n < N; n++) begin
            rdc(12'h100 + 12'(8 * n), 64'h0);
        end
        rdc(12'h100 + 12'(8 * N), 64'h0);
    endtask : t_reset
    task automatic t_fields;
        wr(12'h108, 64'hffff_ffff_ffff_fff6);
        rdc(12'h108, 64'h0fff_ffff_0000_0f06);
        wr(12'h108, 64'h0000_0001_0000_0101);
        wr(12'h108, 64'h0000_0002_0000_0207);
        rdc(12'h108, 64'h0000_0001_0000_0101);
        wr(12'h108, 64'h0);
        rdc(12'h108, 64'h0000_0001_0000_0100);
    endtask : t_fields
    task automatic t_events;
        for (int c = 0; c < 6; c++) begin
            wr(12'h100, 64'h0);
            wr(12'h100, {4'h0, 28'h800_0000, 20'h0, 4'(c), 8'h01});
            ev(c % 5 * 28 + 27, {3'b000, c < 5 && c != 1});
            ev(c % 5 * 28 + 26, 4'b0000);
        end
        wr(12'h100, 64'h0);
        ev(27, 4'b0000);
        wr(12'h100, 64'h0800_0000_0000_0401);
    endtask : t_events
    task automatic t_overflow;
        wr(12'h108, 64'h0000_0001_0000_0107);
        ovf(4'b0010, 1'b1, 4'b0011);
        ev(139, 4'b0000);
        rdc(12'h020, 64'h3);
        rdc(12'h030, 64'h2);
        wr(12'h030, 64'h2);
        rdc(12'h030, 64'h0);
        wr(12'h020, 64'hf);
        rdc(12'h020, 64'h3);
        wr(12'h020, 64'h0);
        ev(139, 4'b0001);
        ovf(4'b0001, 1'b0, 4'b0000);
        @(posedge i_core_clk);
        i_cap_freeze_support <= 1'b0;
        i_cap_intr_support <= 1'b0;
        wr(12'h020, 64'h3);
        rdc(12'h020, 64'h0);
        chk(64'(o_frozen), 64'h0);
        ovf(4'b0010, 1'b0, 4'b0000);
        rdc(12'h030, 64'h3);
    endtask : t_overflow

    // Closing report, the only place the run ends.
    task automatic test_done;
        if (failures == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : test_done

    // Main sequence after four cycles of reset.
    initial begin
        repeat (4) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        t_reset();
        t_fields();
        t_events();
        t_overflow();
        test_done();
    end
endmodule : pmc_config_tb
